/* File: logic/dma_channel_cfg.svh */
// constants of the descriptor channel: offsets, fields, codes
`ifndef DMA_CHANNEL_CFG_SVH
`define DMA_CHANNEL_CFG_SVH
`define NULL_PTR 32'h0000_0000
`define ADDR_STEP 32'h0000_0004
`define WORD_BYTES 16'h0004
`define FULL_WORD 3'h4
`define LAST_IDX 2'h3
`define STAT_IDX 2'h3
`define LEN_MARKER 16
`define LEN_CREDIT 17
`define ST_SOF 16
`define ST_EOF 17
`define ST_ABORT 18
`define ST_PD 19
`define OFS_HI 31
`define OFS_LO 20
`define OFS_WORD_LO 22
`define CNT_HI 15
`define XTR_CH_COUNT 2
`define CST_DISABLED 2'h0
`define CST_UPDATING 2'h1
`define CST_ACTIVE 2'h2
`endif

/* File: logic/dma_descriptor_channel.sv */
// one frame DMA channel walking a chain of control blocks
//
// Contract
// - a buffer never holds bytes of two frames.
// - frame bytes go in network order, earliest byte lowest.
// - software gives offset and injection length; extraction writes length.
// - word 0 is next pointer, word aligned; NULL ends the list.
// - word 2 holds buffer bytes; engine never writes that word.
// - extraction status sets bit 18 on abort, bit 19 on prune.
// - injection aborts the frame if bit 18 or 19 set at load.
// - injection sets status bit 19 when the block is finished.
// - injection with credit bit spends one credit, waits at zero.
// - loading a block with marker bit bumps the marker counter.
// - activate with a valid next pointer fetches and starts.
// - disable request waits for block end and status write.
// - channel reports disabled, updating or active; resets disabled.
// - NULL next pointer on leaving active disables the channel.
// - list end: extraction on load, injection on status write.
// - activate cancels a pending disable or restarts a stopped one.
// - current block address shown; no refetch on reactivation.
// - stop on frame end or every block, raising list end.
// - frame counter on unaborted EOF status; block counter per fetch.
// - marker increments can raise an enabled channel interrupt.
// - channels 0 and 1 extract fixed groups; others inject selected.
`timescale 1ns/1ns
`include "dma_channel_cfg.svh"
module dma_descriptor_channel import dma_pkg::*; #(
  parameter int CHANNEL = 0,
  parameter int CNT_W = 8,
  parameter int CREDIT_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // software control
  input wire logic channel_activate,
  input wire logic channel_disable_request,
  input wire logic next_ptr_write,
  input wire logic [31:0] next_ptr_value,
  input wire logic stop_on_frame_end,
  input wire logic stop_on_every_block,
  input wire logic inj_group_sel,
  input wire logic marker_irq_enable,
  input wire logic credit_write,
  input wire logic [CREDIT_W-1:0] credit_value,
  // software status
  output logic [1:0] channel_state,
  output logic channel_safe_flag,
  output logic [31:0] channel_next_pointer,
  output logic [31:0] channel_current_pointer,
  output logic [CNT_W-1:0] marker_counter,
  output logic [CNT_W-1:0] block_fetch_counter,
  output logic [CNT_W-1:0] frame_counter,
  output logic [CREDIT_W-1:0] injection_credit_count,
  output logic list_end_event,
  output logic marker_event,
  output logic marker_irq,
  output logic queue_group,
  // host memory
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // extraction stream from the queues
  input wire logic xtr_valid,
  input wire logic [31:0] xtr_data,
  input wire logic [2:0] xtr_bytes,
  input wire logic xtr_eof,
  input wire logic xtr_abort,
  input wire logic xtr_pruned,
  output logic xtr_ready,
  // injection stream to the queues
  output logic inj_valid,
  output logic [31:0] inj_data,
  output logic [2:0] inj_bytes,
  output logic inj_sof,
  output logic inj_eof,
  output logic inj_abort,
  input wire logic inj_ready
);
  localparam bit IS_XTR = (CHANNEL < `XTR_CH_COUNT);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic word_t word_at(word_t base, logic [1:0] idx);
    return base + {28'h0000000, idx, 2'h0};
  endfunction : word_at

  function automatic logic [2:0] chunk(logic [15:0] rest);
    return (rest >= `WORD_BYTES) ? `FULL_WORD : rest[2:0];
  endfunction : chunk

  // ----------------------------------------
  // state
  // ----------------------------------------
  chan_state_t state;
  word_t link_w;
  word_t buf_w;
  word_t len_w;
  word_t stat_w;
  logic [1:0] idx;
  logic [15:0] moved;
  logic [15:0] addr_off;
  logic f_sof;
  logic f_eof;
  logic f_abort;
  logic f_pd;
  logic in_frame;
  logic first_word;
  logic pending_off;

  mem_cmd_if cmd ();

  host_word_port u_port (
    .clk(clk),
    .rst_n(rst_n),
    .cmd(cmd.port),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  // ----------------------------------------
  // strobes
  // ----------------------------------------
  logic load_now;
  logic stat_done;
  logic take;
  logic stop_opt;
  logic stop_now;
  logic [15:0] inj_rest;
  word_t stat_out;

  always_comb begin
    load_now = (state == ST_LOAD);
    stat_done = (state == ST_SWAIT) && cmd.done;
    take = (state == ST_MOVE) && xtr_valid && xtr_ready;
    stop_opt = stop_on_every_block || (stop_on_frame_end && f_eof);
    stop_now = pending_off || stop_opt
               || (channel_next_pointer == `NULL_PTR);
    inj_rest = stat_w[`CNT_HI:0] - moved;
    if (IS_XTR) begin
      // offset kept as loaded, flags and length from the transfer
      stat_out = {stat_w[`OFS_HI:`OFS_LO], f_pd, f_abort, f_eof, f_sof,
                  moved};
    end else begin
      stat_out = stat_w;
      stat_out[`ST_PD] = 1'b1;
    end
  end

  // ----------------------------------------
  // channel sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_OFF;
      idx <= 2'h0;
      link_w <= 32'h0000_0000;
      buf_w <= 32'h0000_0000;
      len_w <= 32'h0000_0000;
      stat_w <= 32'h0000_0000;
      moved <= 16'h0000;
      addr_off <= 16'h0000;
      f_sof <= 1'b0;
      f_eof <= 1'b0;
      f_abort <= 1'b0;
      f_pd <= 1'b0;
      in_frame <= 1'b0;
      first_word <= 1'b0;
      cmd.req <= 1'b0;
      cmd.we <= 1'b0;
      cmd.addr <= 32'h0000_0000;
      cmd.wdata <= 32'h0000_0000;
      xtr_ready <= 1'b0;
      inj_valid <= 1'b0;
      inj_data <= 32'h0000_0000;
      inj_bytes <= 3'h0;
      inj_sof <= 1'b0;
      inj_eof <= 1'b0;
      inj_abort <= 1'b0;
    end else begin
      cmd.req <= 1'b0;
      inj_abort <= 1'b0;
      xtr_ready <= 1'b0;
      unique case (state)
        ST_OFF: begin
          if (channel_activate && channel_next_pointer != `NULL_PTR) begin
            state <= ST_FETCH;
            idx <= 2'h0;
            cmd.req <= 1'b1;
            cmd.we <= 1'b0;
            cmd.addr <= channel_next_pointer;
          end
        end
        ST_FETCH: begin
          if (cmd.done) begin
            unique case (idx)
              2'h0: link_w <= cmd.rdata;
              2'h1: buf_w <= cmd.rdata;
              2'h2: len_w <= cmd.rdata;
              2'h3: stat_w <= cmd.rdata;
            endcase
            if (idx == `LAST_IDX) begin
              state <= ST_LOAD;
            end else begin
              idx <= idx + 2'h1;
              cmd.req <= 1'b1;
              cmd.addr <= word_at(channel_current_pointer, idx + 2'h1);
            end
          end
        end
        ST_LOAD: begin
          moved <= 16'h0000;
          first_word <= 1'b1;
          // start of the word that holds the first frame byte
          addr_off <= {4'h0, stat_w[`OFS_HI:`OFS_WORD_LO], 2'h0};
          if (IS_XTR) begin
            f_sof <= 1'b0;
            f_eof <= 1'b0;
            f_abort <= 1'b0;
            f_pd <= 1'b0;
            state <= ST_MOVE;
          end else begin
            f_sof <= stat_w[`ST_SOF];
            f_eof <= stat_w[`ST_EOF];
            f_abort <= stat_w[`ST_ABORT] || stat_w[`ST_PD];
            f_pd <= 1'b0;
            if (stat_w[`ST_ABORT] || stat_w[`ST_PD]) begin
              inj_abort <= 1'b1;
              state <= ST_STAT;
            end else if (len_w[`LEN_CREDIT]) begin
              state <= ST_CRED;
            end else begin
              state <= ST_MOVE;
            end
          end
        end
        ST_CRED: begin
          if (injection_credit_count != '0) begin
            state <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          if (IS_XTR) begin
            if (take) begin
              // first byte of the stream word lands at the lowest address
              cmd.req <= 1'b1;
              cmd.we <= 1'b1;
              cmd.addr <= buf_w + {16'h0000, addr_off};
              cmd.wdata <= xtr_data;
              moved <= moved + {13'h0000, xtr_bytes};
              first_word <= 1'b0;
              if (first_word && !in_frame) begin
                f_sof <= 1'b1;
              end
              in_frame <= !xtr_eof;
              f_eof <= xtr_eof;
              f_abort <= f_abort || xtr_abort;
              f_pd <= f_pd || xtr_pruned;
              state <= ST_MWAIT;
            end else begin
              xtr_ready <= 1'b1;
            end
          end else if (inj_rest == 16'h0000) begin
            state <= ST_STAT;
          end else begin
            cmd.req <= 1'b1;
            cmd.we <= 1'b0;
            cmd.addr <= buf_w + {16'h0000, addr_off};
            state <= ST_MWAIT;
          end
        end
        ST_MWAIT: begin
          if (cmd.done) begin
            addr_off <= addr_off + `WORD_BYTES;
            if (IS_XTR) begin
              // stop before a word that would overrun the buffer
              if (f_eof || ({1'b0, addr_off} + {1'b0, `WORD_BYTES}
                  + {1'b0, `WORD_BYTES}) > {1'b0, len_w[`CNT_HI:0]}) begin
                state <= ST_STAT;
              end else begin
                state <= ST_MOVE;
              end
            end else begin
              inj_valid <= 1'b1;
              inj_data <= cmd.rdata;
              inj_bytes <= chunk(inj_rest);
              inj_sof <= first_word && f_sof;
              inj_eof <= (inj_rest <= `WORD_BYTES) && f_eof;
              state <= ST_PUSH;
            end
          end
        end
        ST_PUSH: begin
          if (inj_ready) begin
            inj_valid <= 1'b0;
            first_word <= 1'b0;
            moved <= moved + {13'h0000, inj_bytes};
            state <= (inj_rest <= `WORD_BYTES) ? ST_STAT : ST_MOVE;
          end else begin
            inj_valid <= 1'b1;
          end
        end
        ST_STAT: begin
          cmd.req <= 1'b1;
          cmd.we <= 1'b1;
          cmd.addr <= word_at(channel_current_pointer, `STAT_IDX);
          cmd.wdata <= stat_out;
          state <= ST_SWAIT;
        end
        ST_SWAIT: begin
          if (cmd.done) begin
            if (stop_now) begin
              state <= ST_OFF;
            end else begin
              state <= ST_FETCH;
              idx <= 2'h0;
              cmd.req <= 1'b1;
              cmd.we <= 1'b0;
              cmd.addr <= channel_next_pointer;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // pointers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      channel_next_pointer <= `NULL_PTR;
      channel_current_pointer <= `NULL_PTR;
    end else begin
      if (load_now) begin
        channel_next_pointer <= link_w;
      end else if (next_ptr_write) begin
        channel_next_pointer <= next_ptr_value;
      end
      // current block stays put across a stop, so no refetch
      if ((state == ST_OFF && channel_activate
           && channel_next_pointer != `NULL_PTR)
          || (stat_done && !stop_now)) begin
        channel_current_pointer <= channel_next_pointer;
      end
    end
  end

  // ----------------------------------------
  // disable request and status
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pending_off <= 1'b0;
      channel_state <= `CST_DISABLED;
      channel_safe_flag <= 1'b1;
      queue_group <= 1'b0;
    end else begin
      if (channel_activate) begin
        pending_off <= 1'b0;
      end else if (stat_done && stop_now) begin
        pending_off <= 1'b0;
      end else if (channel_disable_request && state != ST_OFF) begin
        pending_off <= 1'b1;
      end
      unique case (state)
        ST_OFF: channel_state <= `CST_DISABLED;
        ST_FETCH, ST_LOAD, ST_STAT, ST_SWAIT:
          channel_state <= `CST_UPDATING;
        default: channel_state <= `CST_ACTIVE;
      endcase
      channel_safe_flag <= (state == ST_OFF);
      queue_group <= IS_XTR ? 1'(CHANNEL) : inj_group_sel;
    end
  end

  // ----------------------------------------
  // counters and events
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      marker_counter <= '0;
      block_fetch_counter <= '0;
      frame_counter <= '0;
      list_end_event <= 1'b0;
      marker_event <= 1'b0;
      marker_irq <= 1'b0;
    end else begin
      marker_event <= load_now && len_w[`LEN_MARKER];
      marker_irq <= load_now && len_w[`LEN_MARKER]
                    && marker_irq_enable;
      if (load_now && len_w[`LEN_MARKER]) begin
        marker_counter <= marker_counter + 1'b1;
      end
      if (load_now) begin
        block_fetch_counter <= block_fetch_counter + 1'b1;
      end
      if (stat_done && f_eof && !f_abort) begin
        frame_counter <= frame_counter + 1'b1;
      end
      list_end_event <= (IS_XTR && load_now && link_w == `NULL_PTR)
                        || (!IS_XTR && stat_done && link_w == `NULL_PTR)
                        || (stat_done && stop_opt);
    end
  end

  // ----------------------------------------
  // injection credits
  // ----------------------------------------
  // a write replaces the count; software must not race a spend
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      injection_credit_count <= '0;
    end else if (credit_write) begin
      injection_credit_count <= credit_value;
    end else if (state == ST_CRED && injection_credit_count != '0) begin
      injection_credit_count <= injection_credit_count - 1'b1;
    end
  end
endmodule : dma_descriptor_channel

/* File: logic/dma_pkg.sv */
// types shared by the descriptor channel modules
package dma_pkg;
  typedef logic [31:0] word_t;
  typedef enum logic [8:0] {
    ST_OFF   = 9'h001,
    ST_FETCH = 9'h002,
    ST_LOAD  = 9'h004,
    ST_CRED  = 9'h008,
    ST_MOVE  = 9'h010,
    ST_MWAIT = 9'h020,
    ST_PUSH  = 9'h040,
    ST_STAT  = 9'h080,
    ST_SWAIT = 9'h100
  } chan_state_t;
endpackage : dma_pkg

/* File: logic/host_word_port.sv */
// single-word host memory port with request/acknowledge pins
`timescale 1ns/1ns
module host_word_port (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // engine side
  mem_cmd_if.port cmd,
  // host memory pins
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  // ----------------------------------------
  // one word in flight at a time
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      cmd.done <= 1'b0;
      cmd.rdata <= 32'h0000_0000;
    end else begin
      cmd.done <= 1'b0;
      if (!mem_req && cmd.req) begin
        mem_req <= 1'b1;
        mem_we <= cmd.we;
        mem_addr <= cmd.addr;
        mem_wdata <= cmd.wdata;
      end else if (mem_req && mem_ack) begin
        mem_req <= 1'b0;
        cmd.done <= 1'b1;
        cmd.rdata <= mem_rdata;
      end
    end
  end
endmodule : host_word_port

/* File: logic/mem_cmd_if.sv */
// word command carrier between channel engine and memory port
`timescale 1ns/1ns
interface mem_cmd_if;
  logic req;
  logic we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic done;
  logic [31:0] rdata;
  modport engine (output req, we, addr, wdata, input done, rdata);
  modport port (input req, we, addr, wdata, output done, rdata);
endinterface : mem_cmd_if

/* File: verif/dma_descriptor_channel_asserts.sv */
// concurrent checks on the descriptor channel ports
`timescale 1ns/1ns
module dma_descriptor_channel_asserts #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control and status
  input wire logic channel_activate,
  input wire logic inj_group_sel,
  input wire logic [1:0] channel_state,
  input wire logic channel_safe_flag,
  input wire logic [31:0] channel_next_pointer,
  input wire logic [CNT_W-1:0] marker_counter,
  input wire logic [CNT_W-1:0] block_fetch_counter,
  input wire logic [CNT_W-1:0] frame_counter,
  input wire logic queue_group,
  // memory and stream
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic inj_valid,
  input wire logic inj_ready,
  input wire logic [31:0] inj_data,
  input wire logic [2:0] inj_bytes
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_reset_vals: assert property (disable iff (1'b0)
    !rst_n |=> channel_state == 2'h0 && channel_safe_flag)
    else $error("state not cleared by reset");
  chk_activate_fetch: assert property (
    channel_activate && channel_state == 2'h0 && channel_safe_flag &&
    channel_next_pointer != 32'h0 |->
    ##[2:3] mem_req && mem_addr == channel_next_pointer)
    else $error("activate did not fetch the next block");
  chk_null_idle: assert property (
    channel_activate && channel_state == 2'h0 &&
    channel_next_pointer == 32'h0 |=> !mem_req [*3])
    else $error("fetch started from a null pointer");
  chk_req_hold: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) &&
    $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request changed before ack");
  chk_req_drop: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request held after ack");
  chk_word_align: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
    else $error("unaligned memory address");
  chk_status_only: assert property (
    mem_req && mem_we |-> mem_addr[3:0] == 4'hC && mem_wdata[19])
    else $error("write outside status word or done clear");
  chk_marker_step: assert property (
    $changed(marker_counter) |->
    marker_counter == $past(marker_counter) + 1'b1)
    else $error("marker counter jumped");
  chk_block_step: assert property (
    $changed(block_fetch_counter) |->
    block_fetch_counter == $past(block_fetch_counter) + 1'b1)
    else $error("block counter jumped");
  chk_frame_step: assert property (
    $changed(frame_counter) |->
    frame_counter == $past(frame_counter) + 1'b1)
    else $error("frame counter jumped");
  chk_inj_hold: assert property (
    inj_valid && !inj_ready |=> inj_valid && $stable(inj_data) &&
    $stable(inj_bytes))
    else $error("injection word changed before taken");
  chk_group_sel: assert property (
    $past(rst_n) |-> queue_group == $past(inj_group_sel))
    else $error("queue group does not follow selection");
endmodule : dma_descriptor_channel_asserts
bind dma_descriptor_channel dma_descriptor_channel_asserts #(
  .CNT_W(CNT_W)
) dma_descriptor_channel_asserts_inst (
  .clk, .rst_n, .channel_activate, .inj_group_sel, .channel_state,
  .channel_safe_flag, .channel_next_pointer, .marker_counter,
  .block_fetch_counter, .frame_counter, .queue_group, .mem_req,
  .mem_we, .mem_addr, .mem_wdata, .mem_ack, .inj_valid, .inj_ready,
  .inj_data, .inj_bytes
);

/* File: verif/dma_descriptor_channel_test.sv */
// self-checking bench for one injection descriptor channel
`timescale 1ns/1ns
module dma_descriptor_channel_test import dma_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, stall = 1'b0, inj_ready = 1'b0;
  logic channel_activate = 1'b0, channel_disable_request = 1'b0;
  logic next_ptr_write = 1'b0, credit_write = 1'b0;
  logic stop_on_frame_end = 1'b0, stop_on_every_block = 1'b0;
  logic inj_group_sel = 1'b0, marker_irq_enable = 1'b1;
  logic xtr_valid = 1'b0, xtr_eof = 1'b0, xtr_abort = 1'b0;
  logic xtr_pruned = 1'b0;
  logic [2:0] xtr_bytes = 3'h4;
  logic [31:0] next_ptr_value = 32'h0, xtr_data = 32'h0;
  logic [15:0] credit_value = 16'h0;
  logic [1:0] channel_state;
  logic channel_safe_flag, list_end_event, marker_event, marker_irq;
  logic queue_group, mem_req, mem_we, mem_ack, xtr_ready, inj_valid;
  logic inj_sof, inj_eof, inj_abort;
  logic [31:0] channel_next_pointer, channel_current_pointer, mem_addr;
  logic [31:0] mem_wdata, mem_rdata, inj_data, a;
  logic [7:0] marker_counter, block_fetch_counter, frame_counter;
  logic [15:0] injection_credit_count;
  logic [2:0] inj_bytes;
  logic [36:0] exp_q [$];
  logic [31:0] seed = 32'h0000_B650;
  int mismatches = 0, n_tests = 0, n_le = 0, n_ab = 0, n_mi = 0, e;

  dma_descriptor_channel #(.CHANNEL(2)) dma_descriptor_channel_inst (
    .clk, .rst_n, .channel_activate, .channel_disable_request,
    .next_ptr_write, .next_ptr_value, .stop_on_frame_end,
    .stop_on_every_block, .inj_group_sel, .marker_irq_enable,
    .credit_write, .credit_value, .channel_state, .channel_safe_flag,
    .channel_next_pointer, .channel_current_pointer, .marker_counter,
    .block_fetch_counter, .frame_counter, .injection_credit_count,
    .list_end_event, .marker_event, .marker_irq, .queue_group, .mem_req,
    .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .xtr_valid,
    .xtr_data, .xtr_bytes, .xtr_eof, .xtr_abort, .xtr_pruned, .xtr_ready,
    .inj_valid, .inj_data, .inj_bytes, .inj_sof, .inj_eof, .inj_abort,
    .inj_ready
  );
  host_mem_model host_mem_model_inst (
    .clk, .rst_n, .stall, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always #5 clk = ~clk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic print_verdict();
    if (mismatches == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // descriptor plus buffer; expected stream words go to the queue
  task automatic blk(input logic [31:0] da, nx, bp, w2, st);
    int n;
    logic [31:0] d;
    logic [2:0] b;
    host_mem_model_inst.mem[da[13:2]] = nx;
    host_mem_model_inst.mem[da[13:2] + 1] = bp;
    host_mem_model_inst.mem[da[13:2] + 2] = w2;
    host_mem_model_inst.mem[da[13:2] + 3] = st;
    n = (int'(st[15:0]) + 3) / 4;
    for (int i = 0; i < n; i++) begin
      d = xs();
      b = (i < n - 1) ? 3'h4 : 3'((int'(st[15:0]) - 1) % 4 + 1);
      host_mem_model_inst.mem[bp[13:2] + i] = d;
      if (st[19:18] == 2'h0)
        exp_q.push_back({st[16] && i == 0, st[17] && i == n - 1, b, d});
    end
  endtask : blk
  task automatic act();
    @(posedge clk) channel_activate <= 1'b1;
    @(posedge clk) channel_activate <= 1'b0;
  endtask : act
  task automatic setp(input logic [31:0] v);
    @(posedge clk) begin
      next_ptr_write <= 1'b1;
      next_ptr_value <= v;
    end
    @(posedge clk) next_ptr_write <= 1'b0;
  endtask : setp
  task automatic wait_off();
    int k;
    k = 0;
    while (channel_state === 2'h0 && k < 20) begin
      @(negedge clk);
      k++;
    end
    while (channel_state !== 2'h0 && k < 4000) begin
      @(negedge clk);
      k++;
    end
    check(k < 4000, 1'b1);
    repeat (4) @(negedge clk);
  endtask : wait_off

  // ----------------------------------------
  // random stimulus, stream monitor, events
  // ----------------------------------------
  always @(posedge clk) begin : rnd
    logic [31:0] r;
    r = xs();
    inj_ready <= r[0] | r[1];
    stall <= r[2] & r[3];
    xtr_valid <= r[4];
    xtr_data <= r;
    inj_group_sel <= r[5];
  end
  always @(posedge clk) begin : mon
    if (rst_n && inj_valid && inj_ready) begin
      check(exp_q.size() != 0, 1'b1);
      if (exp_q.size() != 0)
        check({inj_sof, inj_eof, inj_bytes, inj_data},
              exp_q.pop_front());
    end
    n_le <= n_le + int'(list_end_event);
    n_ab <= n_ab + int'(inj_abort);
    n_mi <= n_mi + int'(marker_irq);
    if (rst_n) check(marker_irq, marker_event);
  end
  initial begin : watchdog
    #500000;
    mismatches++;
    print_verdict();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    stop_on_frame_end <= 1'b1;
    @(negedge clk);
    check({channel_state, channel_safe_flag}, 3'h1);
    check(block_fetch_counter, 0);
    blk(32'h100, 32'h200, 32'h1000, 32'hA501_0008, 32'h0001_0006);
    blk(32'h200, 32'h0, 32'h1100, 32'h0002_0004, 32'h0002_0004);
    setp(32'h100);
    act();
    repeat (300) @(negedge clk);
    check(exp_q.size(), 1);
    @(posedge clk) begin
      credit_write <= 1'b1;
      credit_value <= 16'h0001;
    end
    @(posedge clk) credit_write <= 1'b0;
    wait_off();
    check(injection_credit_count, 0);
    check(marker_counter, 1);
    check(block_fetch_counter, 2);
    check(frame_counter, 1);
    check(host_mem_model_inst.mem[12'h043], 32'h0009_0006);
    check(host_mem_model_inst.mem[12'h083], 32'h000A_0004);
    check(host_mem_model_inst.mem[12'h042], 32'hA501_0008);
    check(channel_current_pointer, 32'h200);
    check(channel_next_pointer, 32'h0);
    check(n_le, 1);
    check(n_mi, 1);
    act();
    repeat (10) @(negedge clk);
    check({channel_state, block_fetch_counter}, 10'h002);
    for (int i = 0; i < 2; i++) begin
      blk(32'h300, 32'h0, 32'h1200, 32'h0000_0008,
          32'h0002_0008 | (32'h0004_0000 << i));
      setp(32'h300);
      act();
      wait_off();
      check(n_ab, i + 1);
      check(frame_counter, 1);
    end
    for (int i = 0; i < 2; i++) begin
      a = 32'h400 + 32'h200 * i;
      blk(a, a + 32'h100, 32'h1300, 32'h0000_0008, 32'h0001_0004);
      blk(a + 32'h100, 32'h0, 32'h1400, 32'h0000_0004, 32'h0002_0004);
      @(posedge clk) stop_on_every_block <= (i == 0);
      e = n_le;
      setp(a);
      act();
      if (i == 1) begin
        @(posedge clk) channel_disable_request <= 1'b1;
        @(posedge clk) channel_disable_request <= 1'b0;
      end
      wait_off();
      check(channel_current_pointer, a);
      check(channel_next_pointer, a + 32'h100);
      check(block_fetch_counter, 5 + 2 * i);
      check(n_le - e, 1 - i);
      @(posedge clk) stop_on_every_block <= 1'b0;
      act();
      wait_off();
      check(block_fetch_counter, 6 + 2 * i);
      check(frame_counter, 2 + i);
      check(exp_q.size(), 0);
    end
    print_verdict();
  end
endmodule : dma_descriptor_channel_test

/* File: verif/host_mem_model.sv */
// host memory model answering single-word requests
`timescale 1ns/1ns
module host_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // stall request from the bench
  input wire logic stall,
  // memory pins
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  // ----------------------------------------
  // word store, also loaded by the bench
  // ----------------------------------------
  logic [31:0] mem [0:4095];
  always @(posedge clk) begin
    if (!rst_n || mem_ack) begin
      mem_ack <= 1'b0;
      // idle data keeps moving so no stale word looks valid
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && !stall) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[13:2]];
      if (mem_we) begin
        mem[mem_addr[13:2]] <= mem_wdata;
      end
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : host_mem_model
